//--- hdl/async_serial_port.sv
// Operation
// - 8-bit mode frame: start 0, eight data bits lsb first, stop 1
// - 8-bit mode accepted frame puts stop bit into rx_ninth_bit
// - 8-bit mode rate from one of two timer overflows, tx and rx separately
// - buffer write loads shifter; sending starts after next divide-by-16 rollover
// - start bit, then shifter output a bit later, first shift one more bit later
// - 8-bit mode shifts zeros in, marker ends frame, tx done at tenth rollover
// - rx samples 16x; falling edge resets counter and loads shifter with 1ffh
// - rx samples at counter states 7, 8, 9 and takes majority
// - non-zero voted start bit resets receiver and resumes hunting
// - 8-bit accept only if rx done clear and (multiproc off or stop one)
// - 9-bit modes frame: start, eight data lsb first, ninth bit, stop
// - fixed-rate 9-bit mode runs at clock/16 or clock/32
// - variable-rate 9-bit mode picks timer per direction via clock selects
// - 9-bit write loads ninth bit; first shift inserts one, then zeros
// - 9-bit modes finish and set tx done at eleventh rollover
// - 9-bit accept only if rx done clear and (multiproc off or ninth one)
// - 9-bit receiver resumes hunting one bit time after final bit
// - 9-bit mode stop bit value never affects buffer, ninth flag or done
// - missing stop sets framing error; bit 7 shows it when view select set
// - framing error flag cleared only by software write
// - framing error set regardless of view select
// - outside fixed-rate 9-bit mode, second timer paces tx or rx when its clock-select bit is set
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_defines.svh"

module async_serial_port #(
	parameter int RATE_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer1_overflow,
	input wire logic timer2_overflow,
	input wire logic rx_line,
	output logic tx_line
);
	import serial_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] serial_control_reg;
	logic mode_select_bit0_reg;
	logic framing_error_flag_reg;
	logic [7:0] power_control_reg;
	logic [1:0] clock_control_reg;
	logic [RATE_W-1:0] rate_div_reg;
	logic [7:0] serial_buffer_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic pready_reg;
	logic tx_line_reg;

	logic access;
	logic wr_control;
	logic wr_buffer;
	logic wr_power;
	logic mapped;
	logic [7:0] control_view;
	serial_mode_t mode;
	logic nine_bit;

	assign access = psel && penable;
	assign wr_control = access && pwrite && paddr == `SP_SERIAL_CONTROL_ADDR;
	assign wr_buffer = access && pwrite && paddr == `SP_SERIAL_BUFFER_ADDR;
	assign wr_power = access && pwrite && paddr == `SP_POWER_CONTROL_ADDR;
	assign mapped = paddr == `SP_SERIAL_CONTROL_ADDR || paddr == `SP_SERIAL_BUFFER_ADDR
		|| paddr == `SP_POWER_CONTROL_ADDR || paddr == `SP_CLOCK_CONTROL_ADDR
		|| paddr == `SP_RATE_DIV_ADDR || paddr == `SP_STATUS_ADDR;
	assign mode = serial_mode_t'({mode_select_bit0_reg, serial_control_reg[`SP_SC_MODE1]});
	assign nine_bit = mode == MODE_9BIT_FIXED || mode == MODE_9BIT_VAR;

	always_comb begin
		control_view = serial_control_reg;
		control_view[`SP_SC_BIT7] = power_control_reg[`SP_PC_ERROR_VIEW] ?
			framing_error_flag_reg : mode_select_bit0_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// bit-rate ticks (16x oversample)
	logic [RATE_W-1:0] fixed_cnt_reg;
	logic fixed_tick;
	logic tx_tick;
	logic rx_tick;
	logic [RATE_W-1:0] fixed_div;

	// fast rate doubles the fixed 9-bit rate: clock/16 vs clock/32
	assign fixed_div = power_control_reg[`SP_PC_FAST_RATE] ? RATE_W'(1) : RATE_W'(2);
	assign fixed_tick = fixed_cnt_reg >= fixed_div - RATE_W'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fixed_cnt_reg <= '0;
		end else if (fixed_tick) begin
			fixed_cnt_reg <= '0;
		end else begin
			fixed_cnt_reg <= fixed_cnt_reg + RATE_W'(1);
		end
	end

	always_comb begin
		if (mode == MODE_9BIT_FIXED) begin
			tx_tick = fixed_tick;
			rx_tick = fixed_tick;
		end else begin
			tx_tick = clock_control_reg[`SP_CC_TX_CLOCK_SELECT] ?
				timer2_overflow : timer1_overflow;
			rx_tick = clock_control_reg[`SP_CC_RX_CLOCK_SELECT] ?
				timer2_overflow : timer1_overflow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmitter
	tx_state_t tx_state_reg;
	logic [3:0] tx_div_reg;
	logic [8:0] tx_shift_reg;
	logic tx_first_reg;
	logic tx_rollover;
	logic tx_last;
	logic tx_done_set;

	assign tx_rollover = tx_tick && tx_div_reg == 4'hf;
	// marker one sits beside the output bit: no further shift, stop bit next
	assign tx_last = !tx_first_reg && tx_shift_reg[8:1] == 8'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_div_reg <= '0;
		end else if (tx_tick) begin
			tx_div_reg <= tx_div_reg + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= '0;
			tx_first_reg <= 1'b0;
			tx_line_reg <= 1'b1;
			tx_done_set <= 1'b0;
		end else begin
			tx_done_set <= 1'b0;
			if (wr_buffer && mode != MODE_SYNC) begin
				// 8-bit: marker one above data; 9-bit: ninth bit above data
				tx_shift_reg <= nine_bit ?
					{serial_control_reg[`SP_SC_TX_NINTH], pwdata[7:0]} :
					{1'b1, pwdata[7:0]};
				tx_first_reg <= 1'b1;
				tx_state_reg <= TX_WAIT;
			end else begin
				unique case (tx_state_reg)
					TX_IDLE: begin
						tx_line_reg <= 1'b1;
					end
					TX_WAIT: begin
						if (tx_rollover) begin
							tx_line_reg <= 1'b0;
							tx_state_reg <= TX_START;
						end
					end
					TX_START: begin
						if (tx_rollover) begin
							tx_line_reg <= tx_shift_reg[0];
							tx_state_reg <= TX_DATA;
						end
					end
					TX_DATA: begin
						if (tx_rollover) begin
							if (tx_last) begin
								tx_line_reg <= 1'b1;
								tx_state_reg <= TX_IDLE;
								tx_done_set <= 1'b1;
							end else begin
								// 9-bit: first shift inserts the marker one, zeros after it
								tx_shift_reg <= {nine_bit && tx_first_reg,
									tx_shift_reg[8:1]};
								tx_first_reg <= 1'b0;
								tx_line_reg <= tx_shift_reg[1];
							end
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver
	rx_state_t rx_state_reg;
	logic [3:0] rx_div_reg;
	logic [3:0] rx_bit_reg;
	logic [8:0] rx_shift_reg;
	logic [2:0] rx_votes_reg;
	logic rx_line_prev_reg;
	logic rx_voted;
	logic rx_fall;
	logic rx_load;
	logic rx_accept;
	logic rx_frame_err;
	logic rx_ninth_val;

	assign rx_voted = (rx_votes_reg[0] & rx_votes_reg[1]) | (rx_votes_reg[1] & rx_votes_reg[2])
		| (rx_votes_reg[0] & rx_votes_reg[2]);
	assign rx_fall = rx_line_prev_reg && !rx_line;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_line_prev_reg <= 1'b1;
		end else if (rx_tick) begin
			rx_line_prev_reg <= rx_line;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_reg <= RX_HUNT;
			rx_div_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= `SP_RX_ALL_ONES;
			rx_votes_reg <= 3'b111;
			rx_load <= 1'b0;
			rx_accept <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_ninth_val <= 1'b0;
		end else begin
			rx_load <= 1'b0;
			rx_frame_err <= 1'b0;
			if (rx_tick) begin
				unique case (rx_state_reg)
					RX_HUNT: begin
						if (rx_fall && serial_control_reg[`SP_SC_RX_ENABLE] && mode != MODE_SYNC) begin
							rx_div_reg <= '0;
							rx_shift_reg <= `SP_RX_ALL_ONES;
							rx_bit_reg <= '0;
							rx_state_reg <= RX_FRAME;
						end
					end
					RX_FRAME, RX_TAIL: begin
						rx_div_reg <= rx_div_reg + 4'h1;
						if (rx_div_reg == `SP_SAMPLE_FIRST) rx_votes_reg[0] <= rx_line;
						if (rx_div_reg == `SP_SAMPLE_MID) rx_votes_reg[1] <= rx_line;
						if (rx_div_reg == `SP_SAMPLE_LAST) rx_votes_reg[2] <= rx_line;
						if (rx_div_reg == 4'hf) begin
							rx_bit_reg <= rx_bit_reg + 4'h1;
							if (rx_state_reg == RX_TAIL) begin
								// stop bit after 9-bit frame, only checked for framing
								rx_frame_err <= !rx_voted;
								rx_state_reg <= RX_HUNT;
							end else if (rx_bit_reg == 4'h0 && rx_voted) begin
								rx_state_reg <= RX_HUNT;
							end else if (rx_shift_reg[0] == 1'b0) begin
								// start bit reached the far end: final bit, no shift
								rx_load <= 1'b1;
								rx_ninth_val <= rx_voted;
								rx_accept <= !serial_control_reg[`SP_SC_RX_DONE] &&
									(!serial_control_reg[`SP_SC_MULTIPROC] || rx_voted);
								if (!nine_bit) begin
									rx_frame_err <= !rx_voted;
									rx_state_reg <= RX_HUNT;
								end else begin
									rx_state_reg <= RX_TAIL;
								end
							end
							// no shift at the final bit: the buffer loads this frame next cycle
							if (rx_state_reg == RX_FRAME && rx_shift_reg[0])
								rx_shift_reg <= {rx_voted, rx_shift_reg[8:1]};
						end
					end
					default: rx_state_reg <= RX_HUNT;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial control, buffer and other registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_control_reg <= `SP_SERIAL_CONTROL_RESET;
			mode_select_bit0_reg <= 1'b0;
		end else begin
			if (wr_control) begin
				serial_control_reg <= pwdata[7:0];
				if (!power_control_reg[`SP_PC_ERROR_VIEW])
					mode_select_bit0_reg <= pwdata[`SP_SC_BIT7];
			end
			if (tx_done_set)
				serial_control_reg[`SP_SC_TX_DONE] <= 1'b1;
			if (rx_load && rx_accept) begin
				serial_control_reg[`SP_SC_RX_DONE] <= 1'b1;
				serial_control_reg[`SP_SC_RX_NINTH] <= rx_ninth_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framing_error_flag_reg <= 1'b0;
		end else if (rx_frame_err) begin
			framing_error_flag_reg <= 1'b1;
		end else if (wr_control && power_control_reg[`SP_PC_ERROR_VIEW]
			&& !pwdata[`SP_SC_BIT7]) begin
			framing_error_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_buffer_reg <= '0;
		end else if (rx_load && rx_accept) begin
			serial_buffer_reg <= rx_shift_reg[8:1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_control_reg <= `SP_POWER_CONTROL_RESET;
			clock_control_reg <= '0;
			rate_div_reg <= `SP_RATE_DIV_RESET;
		end else if (access && pwrite) begin
			if (wr_power) power_control_reg <= pwdata[7:0];
			if (paddr == `SP_CLOCK_CONTROL_ADDR) clock_control_reg <= pwdata[1:0];
			if (paddr == `SP_RATE_DIV_ADDR) rate_div_reg <= pwdata[RATE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb read path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= psel && !penable && !mapped;
			prdata_reg <= '0;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`SP_SERIAL_CONTROL_ADDR: prdata_reg <= {24'h0, control_view};
					`SP_SERIAL_BUFFER_ADDR: prdata_reg <= {24'h0, serial_buffer_reg};
					`SP_POWER_CONTROL_ADDR: prdata_reg <= {24'h0, power_control_reg};
					`SP_CLOCK_CONTROL_ADDR: prdata_reg <= {30'h0, clock_control_reg};
					`SP_RATE_DIV_ADDR: prdata_reg <= {{(32-RATE_W){1'b0}}, rate_div_reg};
					`SP_STATUS_ADDR: prdata_reg <= {24'h0, framing_error_flag_reg,
						mode_select_bit0_reg, 2'b00, rx_state_reg, tx_state_reg};
					default: prdata_reg <= '0;
				endcase
			end
		end
	end

	// answer in the access cycle that follows each setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel && !penable;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx_line = tx_line_reg;
endmodule : async_serial_port

`default_nettype wire

//--- hdl/serial_port_defines.svh
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// register byte addresses
`define SP_SERIAL_CONTROL_ADDR 12'h000
`define SP_SERIAL_BUFFER_ADDR 12'h004
`define SP_POWER_CONTROL_ADDR 12'h008
`define SP_CLOCK_CONTROL_ADDR 12'h00c
`define SP_RATE_DIV_ADDR 12'h010
`define SP_STATUS_ADDR 12'h014

// serial_control fields
`define SP_SC_RX_DONE 0
`define SP_SC_TX_DONE 1
`define SP_SC_RX_NINTH 2
`define SP_SC_TX_NINTH 3
`define SP_SC_RX_ENABLE 4
`define SP_SC_MULTIPROC 5
`define SP_SC_MODE1 6
`define SP_SC_BIT7 7

// power_control fields
`define SP_PC_FAST_RATE 7
`define SP_PC_ERROR_VIEW 6

// clock control fields
`define SP_CC_RX_CLOCK_SELECT 0
`define SP_CC_TX_CLOCK_SELECT 1

// reset values
`define SP_SERIAL_CONTROL_RESET 8'h00
`define SP_POWER_CONTROL_RESET 8'h00
`define SP_RATE_DIV_RESET 16'h0001

// timing
`define SP_OVERSAMPLE 16
`define SP_SAMPLE_FIRST 4'h7
`define SP_SAMPLE_MID 4'h8
`define SP_SAMPLE_LAST 4'h9
`define SP_RX_ALL_ONES 9'h1ff

`endif

//--- hdl/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;
	typedef enum logic [1:0] {
		MODE_SYNC,
		MODE_8BIT,
		MODE_9BIT_FIXED,
		MODE_9BIT_VAR
	} serial_mode_t;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_WAIT,
		TX_START,
		TX_DATA
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT,
		RX_FRAME,
		RX_TAIL
	} rx_state_t;
endpackage : serial_port_pkg
`default_nettype wire

//--- testbench/async_serial_port_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_assertions #(
	parameter int RATE_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer1_overflow,
	input wire logic timer2_overflow,
	input wire logic rx_line,
	input wire logic tx_line
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] pc_seen_reg;
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_buf_write;
		s_access ##0 (pwrite && paddr == 12'h004);
	endsequence
	// last value written to power_control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pc_seen_reg <= 8'h00;
		else if (psel && penable && pwrite && paddr == 12'h008)
			pc_seen_reg <= pwdata[7:0];
	end
	////////////////////////////////////////
	a_ready_always: assert property (s_access |-> pready)
		else $error("pready low in access");
	a_slverr_unmapped: assert property (s_access ##0 (paddr > 12'h014) |-> pslverr)
		else $error("no error on unmapped access");
	a_slverr_mapped: assert property (s_access ##0 (paddr <= 12'h014 && paddr[1:0] == 2'b00)
		|-> !pslverr) else $error("error on mapped access");
	a_unmapped_zero: assert property (s_access ##0 (!pwrite && paddr > 12'h014)
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	a_select_readback: assert property (s_access ##0 (!pwrite && paddr == 12'h008)
		|-> prdata[7:6] == pc_seen_reg[7:6]) else $error("select bit readback");
	a_tx_low_hold: assert property ($fell(tx_line) |-> !tx_line[*8] ##1 !tx_line[*8])
		else $error("tx low bit too short");
	a_tx_high_hold: assert property ($rose(tx_line) |-> tx_line[*8] ##1 tx_line[*8])
		else $error("tx high bit too short");
	a_tx_not_at_write: assert property (s_buf_write ##0 tx_line |=> tx_line)
		else $error("tx started at the write");
endmodule : async_serial_port_assertions
bind async_serial_port async_serial_port_assertions #(.RATE_W(RATE_W)) u_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
	.rx_line(rx_line), .tx_line(tx_line));
`default_nettype wire

//--- testbench/serial_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
module serial_remote_node (
	input wire logic pclk,
	output logic rx_line,
	input wire logic tx_line
);
	initial rx_line = 1'b1;
	// n of -1 sends only a short low pulse of b cycles
	task automatic send(input logic [8:0] v, input int n, input logic st, input int b);
		for (int i = -1; i <= n; i++) begin
			rx_line <= (i < 0) ? 1'b0 : (i == n) ? st : v[i];
			repeat (b) @(posedge pclk);
		end
		rx_line <= 1'b1;
	endtask : send
	task automatic recv(input int n, input int b, output logic [8:0] d, output logic ok);
		int t;
		t = 0;
		d = 9'h000;
		while (tx_line === 1'b1 && t < 2000) begin
			@(posedge pclk);
			t++;
		end
		repeat (b / 2) @(posedge pclk);
		ok = (tx_line === 1'b0);
		for (int i = 0; i <= n; i++) begin
			repeat (b) @(posedge pclk);
			if (i < n)
				d[i] = tx_line;
			else
				ok = ok & (tx_line === 1'b1);
		end
	endtask : recv
endmodule : serial_remote_node
`default_nettype wire

//--- testbench/tb_async_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_async_serial_port;
	logic pclk, presetn, psel, penable, pwrite, t1, t2, pready, pslverr, rxl, txl, ok, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [8:0] d, v;
	logic [1:0] cyc;
	logic [8:0] exp_q[$];
	int error_cnt, num_checks, seed, ebuf;
	bit rdone, enb;
	async_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer1_overflow(t1), .timer2_overflow(t2), .rx_line(rxl),
		.tx_line(txl));
	serial_remote_node u_node (.pclk(pclk), .rx_line(rxl), .tx_line(txl));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// timer1 ticks every second cycle, timer2 every fourth
	always @(posedge pclk) begin
		cyc <= cyc + 2'd1;
		t1 <= cyc[0];
		t2 <= (cyc == 2'd3);
	end
	////////////////////////////////////////
	task automatic finish_test;
		if (error_cnt == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rx(input logic [8:0] val, input int n, input logic st, input bit mp);
		bit nb;
		nb = (n == 8) ? st : val[8];
		u_node.send(val, n, st, 32);
		repeat (32) @(posedge pclk);
		if (!rdone && (!mp || nb)) begin
			ebuf = val[7:0];
			rdone = 1'b1;
			enb = nb;
		end
		apb(1'b0, 12'h004, 32'h0);
		chk(r, ebuf);
		apb(1'b0, 12'h000, 32'h0);
		chk({r[2], r[0]}, {enb, rdone});
	endtask : rx
	initial begin
		seed = 89488;
		{psel, penable, pwrite, paddr, pwdata, t1, t2, cyc, presetn} = '0;
		{error_cnt, num_checks, ebuf, rdone, enb} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 12'h01c, 32'h0);
		chk(r, 32'h0);
		chk(e, 32'h1);
		apb(1'b1, 12'h000, 32'h50);
		v = {1'b0, 8'($random(seed))};
		exp_q.push_back(v);
		fork
			u_node.recv(8, 32, d, ok);
			apb(1'b1, 12'h004, {24'h0, v[7:0]});
		join
		chk(d, exp_q.pop_front());
		chk(ok, 32'h1);
		repeat (32) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h52);
		u_node.send(9'h0, -1, 1'b1, 4);
		repeat (64) @(posedge pclk);
		rx({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b0);
		rx({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b0);
		apb(1'b1, 12'h008, 32'h40);
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h40);
		apb(1'b1, 12'h000, 32'h50);
		rdone = 1'b0;
		rx({1'b0, 8'($random(seed))}, 8, 1'b0, 1'b0);
		chk(r[7], 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(r[7], 32'h1);
		apb(1'b1, 12'h000, 32'h50);
		rdone = 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(r[7], 32'h0);
		apb(1'b1, 12'h008, 32'h0);
		apb(1'b1, 12'h00c, 32'h2);
		apb(1'b1, 12'h000, 32'hd8);
		v = {1'b1, 8'($random(seed))};
		exp_q.push_back(v);
		fork
			u_node.recv(9, 64, d, ok);
			apb(1'b1, 12'h004, {24'h0, v[7:0]});
		join
		chk(d, exp_q.pop_front());
		chk(ok, 32'h1);
		repeat (64) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		chk(r[1], 32'h1);
		apb(1'b1, 12'h000, 32'hf0);
		rx({1'b0, 8'($random(seed))}, 9, 1'b1, 1'b1);
		rx({1'b1, 8'($random(seed))}, 9, 1'b0, 1'b1);
		// fixed-rate 9-bit mode: slow rate first, then fast rate
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 12'h008, k ? 32'h80 : 32'h00);
			apb(1'b1, 12'h000, 32'h98);
			v = {1'b1, 8'($random(seed))};
			exp_q.push_back(v);
			fork
				u_node.recv(9, k ? 16 : 32, d, ok);
				apb(1'b1, 12'h004, {24'h0, v[7:0]});
			join
			chk(d, exp_q.pop_front());
			chk(ok, 32'h1);
		end
		apb(1'b1, 12'h008, 32'h40);
		apb(1'b0, 12'h000, 32'h0);
		chk(r[7], 32'h1);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end
endmodule : tb_async_serial_port
`default_nettype wire
